// >>> rtl/dp_pkg.sv
// Shared constants and types for the programmable logic block datapath.
// Assumes a single 25 MHz clock and a byte-wide system bus port.
package dp_pkg;

  localparam int DW = 8;
  localparam int AW = 6;
  localparam int QDEPTH = 4;
  localparam int CFG_WORDS = 8;

  // Register offsets on the system bus port
  localparam logic [5:0] OFS_ACC0 = 6'h00;
  localparam logic [5:0] OFS_ACC1 = 6'h01;
  localparam logic [5:0] OFS_OPR0 = 6'h02;
  localparam logic [5:0] OFS_OPR1 = 6'h03;
  localparam logic [5:0] OFS_QUE0 = 6'h04;
  localparam logic [5:0] OFS_QUE1 = 6'h05;
  localparam logic [5:0] OFS_CTRL = 6'h06;
  localparam logic [5:0] OFS_STAT = 6'h07;
  localparam logic [5:0] OFS_MSB = 6'h08;
  localparam logic [5:0] OFS_OMASK = 6'h09;
  localparam logic [5:0] OFS_CMASK0 = 6'h0A;
  localparam logic [5:0] OFS_CMASK1 = 6'h0B;
  localparam logic [5:0] OFS_CMPSEL = 6'h0C;
  localparam logic [5:0] OFS_QDIR = 6'h0D;
  localparam logic [5:0] OFS_POLY = 6'h0E;
  localparam logic [5:0] OFS_STICKY = 6'h0F;
  localparam logic [5:0] OFS_CLKEN = 6'h10;
  localparam logic [5:0] OFS_OSEL0 = 6'h11;
  localparam logic [5:0] OFS_OSEL1 = 6'h12;
  localparam logic [5:0] OFS_OSEL2 = 6'h13;
  localparam logic [5:0] OFS_CHAIN = 6'h14;
  localparam logic [5:0] OFS_QSTAT = 6'h15;
  // Configuration words: base + 2*index + byte (0 low, 1 high)
  localparam logic [5:0] OFS_CFG = 6'h20;

  // Reset values of the static configuration
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONES = 8'hFF;
  localparam logic [2:0] RST_MSB = 3'h7;
  localparam logic [1:0] RST_CLKEN = 2'h3;

  typedef enum logic [2:0] {
    FN_PASS = 3'b000,
    FN_INC = 3'b001,
    FN_DEC = 3'b010,
    FN_ADD = 3'b011,
    FN_SUB = 3'b100,
    FN_AND = 3'b101,
    FN_OR = 3'b110,
    FN_XOR = 3'b111
  } alu_fn_e;

  typedef enum logic [1:0] {
    SH_NONE = 2'b00,
    SH_LEFT = 2'b01,
    SH_RIGHT = 2'b10,
    SH_SWAP = 2'b11
  } shift_e;

  // Operand select: 0 acc0, 1 acc1, 2 opr0, 3 opr1
  typedef logic [1:0] src_t;

  typedef struct packed {
    alu_fn_e fn;
    src_t src_a;
    src_t src_b;
    shift_e shift;
    logic wr_acc0;
    logic wr_acc1;
    logic q_load;
    logic q0_push;
    logic q1_push;
    logic crc_en;
    logic carry_sel;
  } cfg_word_s;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } bus_req_s;

endpackage

// >>> rtl/dp_queue.sv
// Four-entry byte queue with full and empty status.
// Push when full and pop when empty are ignored; both may occur together.
`timescale 1ns/1ps
module dp_queue (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Fill side
  input wire logic push,
  input wire logic [dp_pkg::DW-1:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [dp_pkg::DW-1:0] head,
  // Status
  output logic full,
  output logic empty
);
  logic [dp_pkg::DW-1:0] mem_q [dp_pkg::QDEPTH];
  logic [dp_pkg::DW-1:0] mem_d [dp_pkg::QDEPTH];
  logic [1:0] wp_q, wp_d, rp_q, rp_d;
  logic [2:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  assign full = (cnt_q == 3'h4);
  assign empty = (cnt_q == 3'h0);
  assign head = mem_q[rp_q];

  always_comb begin
    do_push = push && !full;
    do_pop = pop && !empty;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (do_push) begin
      mem_d[wp_q] = push_data;
      wp_d = wp_q + 2'h1;
    end
    if (do_pop) begin
      rp_d = rp_q + 2'h1;
    end
    if (do_push && !do_pop) begin
      cnt_d = cnt_q + 3'h1;
    end else if (do_pop && !do_push) begin
      cnt_d = cnt_q - 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      cnt_q <= 3'h0;
      for (int i = 0; i < dp_pkg::QDEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule

// >>> rtl/programmable_block_datapath.sv
// Datapath of one programmable logic block, with control and status registers.
// Assumes routing inputs already on clk_sys; the bus port is byte wide, one access per cycle.
// What this block does
// - One 8-bit ALU, single cycle per operation.
// - Accumulators are ALU sources, sinks, compare operands.
// - Data registers feed ALU and compares only.
// - Two four-byte queues load or capture datapath values.
// - Each queue direction selectable, input or output.
// - Eight 16-bit config words, routed 3-bit address.
// - Eight ALU functions including inc, dec, logic.
// - Shift left, right, nibble swap, AND mask.
// - Two masked comparators with selectable operand pairs.
// - Zero, all-ones, overflow conditions, selectable outputs.
// - Programmable MSB with output mask.
// - Single-cycle CRC or PSEUDO_RANDOM_SEQUENCE step, any polynomial.
// - Carry, shift and condition chaining to neighbours.
// - Carry and shift-out registered for later use.
// - Six routing inputs and six routing outputs.
// - Queue status selectable as datapath outputs.
// - Bus-written control bits drive routing.
// - Read-only status reflects routing signals.
// - Sticky status bits cleared by register read.
// - Datapath and status/control have own clock enable.
// - Queues are main parallel path to CPU.
`timescale 1ns/1ps
module programmable_block_datapath (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // System bus port
  input wire dp_pkg::bus_req_s bus_req,
  output logic [dp_pkg::DW-1:0] bus_rdata_q,
  // Routing matrix: [2:0] config address, [3] serial in,
  // [4] load data registers from queues, [5] capture accumulators into queues
  input wire logic [5:0] route_in,
  output logic [5:0] route_out_q,
  // Routing signals sampled by the status register
  input wire logic [dp_pkg::DW-1:0] status_route,
  // Control register bits into routing
  output logic [dp_pkg::DW-1:0] ctrl_out_q,
  // Chaining with neighbouring datapaths
  input wire logic chain_carry_in,
  input wire logic chain_shift_in,
  input wire logic chain_cond_in,
  output logic chain_carry_out_q,
  output logic chain_shift_out_q,
  output logic chain_cond_out_q
);
  typedef logic [7:0] byte_t;

  // Working registers
  byte_t acc0_q, acc0_d, acc1_q, acc1_d;
  byte_t opr0_q, opr0_d, opr1_q, opr1_d;
  logic carry_q, carry_d, sout_q, sout_d;
  // Static configuration and control
  byte_t ctrl_q, ctrl_d, omask_q, omask_d, poly_q, poly_d;
  byte_t cmask0_q, cmask0_d, cmask1_q, cmask1_d;
  byte_t sticky_q, sticky_d, held_q, held_d;
  byte_t osel_q [3];
  byte_t osel_d [3];
  logic [2:0] msb_q, msb_d;
  logic [3:0] cmpsel_q, cmpsel_d;
  logic [1:0] qdir_q, qdir_d, clken_q, clken_d, chain_q, chain_d;
  logic [15:0] cfg_q [dp_pkg::CFG_WORDS];
  logic [15:0] cfg_d [dp_pkg::CFG_WORDS];
  byte_t rdata_d;
  logic [5:0] rout_d;
  logic cco_d, cso_d, ccond_d;

  // Queue wiring
  logic q_push [2];
  logic q_pop [2];
  byte_t q_wdata [2];
  byte_t q_head [2];
  logic q_full [2];
  logic q_empty [2];

  // Datapath combinational values
  dp_pkg::cfg_word_s cw;
  byte_t op_a, op_b, wmask, am, bm, r8, sh8, res;
  logic [8:0] r9;
  logic [3:0] top;
  logic ci, si, co, so, ovf, fb, run, sc_run;
  logic bus_wr, bus_rd;
  logic [15:0] cond;

  function automatic byte_t pick(input dp_pkg::src_t s, input byte_t a0, input byte_t a1,
                                 input byte_t d0, input byte_t d1);
    unique case (s)
      2'h0: pick = a0;
      2'h1: pick = a1;
      2'h2: pick = d0;
      2'h3: pick = d1;
    endcase
  endfunction

  // Compare pairs: 0 acc0/opr0, 1 acc1/opr1, 2 acc0/acc1, 3 opr0/opr1
  function automatic logic [1:0] compare(input logic [1:0] s, input byte_t m,
                                         input byte_t a0, input byte_t a1,
                                         input byte_t d0, input byte_t d1);
    byte_t x, y;
    x = 8'h00;
    y = 8'h00;
    unique case (s)
      2'h0: begin
        x = a0 & m;
        y = d0 & m;
      end
      2'h1: begin
        x = a1 & m;
        y = d1 & m;
      end
      2'h2: begin
        x = a0 & m;
        y = a1 & m;
      end
      2'h3: begin
        x = d0 & m;
        y = d1 & m;
      end
    endcase
    compare = {x < y, x == y};
  endfunction

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction

  assign bus_wr = bus_req.sel && bus_req.wr;
  assign bus_rd = bus_req.sel && !bus_req.wr;
  assign run = clken_q[0];
  assign sc_run = clken_q[1];

  // Queue direction: bit set means output buffer
  for (genvar g = 0; g < 2; g++) begin : g_queue
    logic qhit;
    assign qhit = hit(bus_req.addr, dp_pkg::OFS_QUE0 + 6'(g));
    always_comb begin
      if (qdir_q[g]) begin
        q_push[g] = run && ((g == 0 ? cw.q0_push : cw.q1_push) || route_in[5]);
        q_wdata[g] = route_in[5] ? (g == 0 ? acc0_q : acc1_q) : res;
        q_pop[g] = bus_rd && qhit;
      end else begin
        q_push[g] = bus_wr && qhit;
        q_wdata[g] = bus_req.wdata;
        q_pop[g] = run && (cw.q_load || route_in[4]);
      end
    end
    dp_queue u_queue (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .push(q_push[g]),
      .push_data(q_wdata[g]),
      .pop(q_pop[g]),
      .head(q_head[g]),
      .full(q_full[g]),
      .empty(q_empty[g])
    );
  end

  // ALU and result path
  always_comb begin
    cw = dp_pkg::cfg_word_s'(cfg_q[route_in[2:0]]);
    wmask = 8'hFF >> (3'h7 - msb_q);
    top = {1'b0, msb_q} + 4'h1;
    op_a = pick(cw.src_a, acc0_q, acc1_q, opr0_q, opr1_q);
    op_b = pick(cw.src_b, acc0_q, acc1_q, opr0_q, opr1_q);
    am = op_a & wmask;
    bm = op_b & wmask;
    ci = cw.carry_sel ? carry_q : (chain_q[0] && chain_carry_in);
    si = chain_q[1] ? chain_shift_in : route_in[3];
    unique case (cw.fn)
      dp_pkg::FN_PASS: r9 = {1'b0, am};
      dp_pkg::FN_INC: r9 = {1'b0, am} + 9'h001;
      dp_pkg::FN_DEC: r9 = {1'b0, am} - 9'h001;
      dp_pkg::FN_ADD: r9 = {1'b0, am} + {1'b0, bm} + {8'h00, ci};
      dp_pkg::FN_SUB: r9 = {1'b0, am} - {1'b0, bm} - {8'h00, ci};
      dp_pkg::FN_AND: r9 = {1'b0, am & bm};
      dp_pkg::FN_OR: r9 = {1'b0, am | bm};
      dp_pkg::FN_XOR: r9 = {1'b0, am ^ bm};
    endcase
    co = r9[top];
    r8 = r9[7:0] & wmask;
    ovf = 1'b0;
    if (cw.fn == dp_pkg::FN_ADD) begin
      ovf = (am[msb_q] == bm[msb_q]) && (r8[msb_q] != am[msb_q]);
    end else if (cw.fn == dp_pkg::FN_SUB) begin
      ovf = (am[msb_q] != bm[msb_q]) && (r8[msb_q] != am[msb_q]);
    end
    // CRC step takes precedence over the ALU result
    fb = am[msb_q] ^ si;
    if (cw.crc_en) begin
      r8 = ((am << 1) ^ (fb ? poly_q : 8'h00)) & wmask;
      co = fb;
    end
    so = 1'b0;
    unique case (cw.shift)
      dp_pkg::SH_NONE: sh8 = r8;
      dp_pkg::SH_LEFT: begin
        sh8 = {r8[6:0], si} & wmask;
        so = r8[msb_q];
      end
      dp_pkg::SH_RIGHT: begin
        sh8 = (r8 >> 1) | ({7'h00, si} << msb_q);
        so = r8[0];
      end
      dp_pkg::SH_SWAP: sh8 = {r8[3:0], r8[7:4]};
    endcase
    res = sh8 & omask_q;
  end

  // Condition vector offered to the routing outputs
  always_comb begin
    cond[1:0] = compare(cmpsel_q[1:0], cmask0_q, acc0_q, acc1_q, opr0_q, opr1_q);
    cond[3:2] = compare(cmpsel_q[3:2], cmask1_q, acc0_q, acc1_q, opr0_q, opr1_q);
    cond[4] = (acc0_q & wmask) == 8'h00;
    cond[5] = (acc1_q & wmask) == 8'h00;
    cond[6] = (acc0_q & wmask) == wmask;
    cond[7] = (acc1_q & wmask) == wmask;
    cond[8] = ovf;
    cond[9] = carry_q;
    cond[10] = sout_q;
    cond[11] = q_full[0];
    cond[12] = q_empty[0];
    cond[13] = q_full[1];
    cond[14] = q_empty[1];
    cond[15] = chain_cond_in;
  end

  // Working registers, bus writes win over the datapath
  always_comb begin
    acc0_d = acc0_q;
    acc1_d = acc1_q;
    opr0_d = opr0_q;
    opr1_d = opr1_q;
    carry_d = carry_q;
    sout_d = sout_q;
    cco_d = chain_carry_out_q;
    cso_d = chain_shift_out_q;
    ccond_d = chain_cond_out_q;
    if (run) begin
      if (cw.wr_acc0) begin
        acc0_d = res;
      end
      if (cw.wr_acc1) begin
        acc1_d = res;
      end
      // Queue loads only act on input-direction queues holding data
      if (cw.q_load && !qdir_q[0] && !q_empty[0]) begin
        acc0_d = q_head[0];
      end
      if (cw.q_load && !qdir_q[1] && !q_empty[1]) begin
        acc1_d = q_head[1];
      end
      if (route_in[4] && !qdir_q[0] && !q_empty[0]) begin
        opr0_d = q_head[0];
      end
      if (route_in[4] && !qdir_q[1] && !q_empty[1]) begin
        opr1_d = q_head[1];
      end
      carry_d = co;
      sout_d = so;
      cco_d = co;
      cso_d = so;
      ccond_d = cond[0];
    end
    if (bus_wr && hit(bus_req.addr, dp_pkg::OFS_ACC0)) begin
      acc0_d = bus_req.wdata;
    end
    if (bus_wr && hit(bus_req.addr, dp_pkg::OFS_ACC1)) begin
      acc1_d = bus_req.wdata;
    end
    if (bus_wr && hit(bus_req.addr, dp_pkg::OFS_OPR0)) begin
      opr0_d = bus_req.wdata;
    end
    if (bus_wr && hit(bus_req.addr, dp_pkg::OFS_OPR1)) begin
      opr1_d = bus_req.wdata;
    end
  end

  // Configuration, control and status registers
  always_comb begin
    ctrl_d = ctrl_q;
    omask_d = omask_q;
    poly_d = poly_q;
    cmask0_d = cmask0_q;
    cmask1_d = cmask1_q;
    sticky_d = sticky_q;
    osel_d = osel_q;
    msb_d = msb_q;
    cmpsel_d = cmpsel_q;
    qdir_d = qdir_q;
    clken_d = clken_q;
    chain_d = chain_q;
    cfg_d = cfg_q;
    held_d = held_q;
    if (bus_wr) begin
      unique case (bus_req.addr)
        dp_pkg::OFS_CTRL: ctrl_d = bus_req.wdata;
        dp_pkg::OFS_MSB: msb_d = bus_req.wdata[2:0];
        dp_pkg::OFS_OMASK: omask_d = bus_req.wdata;
        dp_pkg::OFS_CMASK0: cmask0_d = bus_req.wdata;
        dp_pkg::OFS_CMASK1: cmask1_d = bus_req.wdata;
        dp_pkg::OFS_CMPSEL: cmpsel_d = bus_req.wdata[3:0];
        dp_pkg::OFS_QDIR: qdir_d = bus_req.wdata[1:0];
        dp_pkg::OFS_POLY: poly_d = bus_req.wdata;
        dp_pkg::OFS_STICKY: sticky_d = bus_req.wdata;
        dp_pkg::OFS_CLKEN: clken_d = bus_req.wdata[1:0];
        dp_pkg::OFS_OSEL0: osel_d[0] = bus_req.wdata;
        dp_pkg::OFS_OSEL1: osel_d[1] = bus_req.wdata;
        dp_pkg::OFS_OSEL2: osel_d[2] = bus_req.wdata;
        dp_pkg::OFS_CHAIN: chain_d = bus_req.wdata[1:0];
        default: begin
          // Only 0x20-0x2F reach the configuration words; 0x30-0x3F stay unmapped
          if (bus_req.addr[5:4] == 2'b10) begin
            if (bus_req.addr[0]) begin
              cfg_d[bus_req.addr[3:1]][15:8] = bus_req.wdata;
            end else begin
              cfg_d[bus_req.addr[3:1]][7:0] = bus_req.wdata;
            end
          end
        end
      endcase
    end
    // Read clears held bits, but a new event in the same cycle is kept
    if (bus_rd && hit(bus_req.addr, dp_pkg::OFS_STAT)) begin
      held_d = 8'h00;
    end
    if (sc_run) begin
      held_d = held_d | (status_route & sticky_q);
    end
  end

  // Routing outputs: each output has a 4-bit condition select
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      rout_d[i] = cond[osel_q[i/2][(i%2)*4 +: 4]];
    end
  end

  // Registered read data; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (bus_rd) begin
      unique case (bus_req.addr)
        dp_pkg::OFS_ACC0: rdata_d = acc0_q;
        dp_pkg::OFS_ACC1: rdata_d = acc1_q;
        dp_pkg::OFS_OPR0: rdata_d = opr0_q;
        dp_pkg::OFS_OPR1: rdata_d = opr1_q;
        dp_pkg::OFS_QUE0: rdata_d = q_head[0];
        dp_pkg::OFS_QUE1: rdata_d = q_head[1];
        dp_pkg::OFS_CTRL: rdata_d = ctrl_q;
        dp_pkg::OFS_STAT: rdata_d = (held_q & sticky_q) | (status_route & ~sticky_q);
        dp_pkg::OFS_MSB: rdata_d = {5'h00, msb_q};
        dp_pkg::OFS_OMASK: rdata_d = omask_q;
        dp_pkg::OFS_CMASK0: rdata_d = cmask0_q;
        dp_pkg::OFS_CMASK1: rdata_d = cmask1_q;
        dp_pkg::OFS_CMPSEL: rdata_d = {4'h0, cmpsel_q};
        dp_pkg::OFS_QDIR: rdata_d = {6'h00, qdir_q};
        dp_pkg::OFS_POLY: rdata_d = poly_q;
        dp_pkg::OFS_STICKY: rdata_d = sticky_q;
        dp_pkg::OFS_CLKEN: rdata_d = {6'h00, clken_q};
        dp_pkg::OFS_OSEL0: rdata_d = osel_q[0];
        dp_pkg::OFS_OSEL1: rdata_d = osel_q[1];
        dp_pkg::OFS_OSEL2: rdata_d = osel_q[2];
        dp_pkg::OFS_CHAIN: rdata_d = {6'h00, chain_q};
        dp_pkg::OFS_QSTAT: rdata_d = {4'h0, q_empty[1], q_full[1], q_empty[0], q_full[0]};
        default: begin
          if (bus_req.addr[5:4] == 2'b10) begin
            rdata_d = bus_req.addr[0] ? cfg_q[bus_req.addr[3:1]][15:8] : cfg_q[bus_req.addr[3:1]][7:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc0_q <= dp_pkg::RST_ZERO;
      acc1_q <= dp_pkg::RST_ZERO;
      opr0_q <= dp_pkg::RST_ZERO;
      opr1_q <= dp_pkg::RST_ZERO;
      ctrl_q <= dp_pkg::RST_ZERO;
      held_q <= dp_pkg::RST_ZERO;
      carry_q <= 1'b0;
      sout_q <= 1'b0;
      omask_q <= dp_pkg::RST_ONES;
      poly_q <= dp_pkg::RST_ZERO;
      cmask0_q <= dp_pkg::RST_ONES;
      cmask1_q <= dp_pkg::RST_ONES;
      sticky_q <= dp_pkg::RST_ZERO;
      osel_q <= '{default: 8'h00};
      msb_q <= dp_pkg::RST_MSB;
      cmpsel_q <= 4'h0;
      qdir_q <= 2'h0;
      clken_q <= dp_pkg::RST_CLKEN;
      chain_q <= 2'h0;
      cfg_q <= '{default: 16'h0000};
      bus_rdata_q <= dp_pkg::RST_ZERO;
      route_out_q <= 6'h00;
      ctrl_out_q <= dp_pkg::RST_ZERO;
      chain_carry_out_q <= 1'b0;
      chain_shift_out_q <= 1'b0;
      chain_cond_out_q <= 1'b0;
    end else begin
      acc0_q <= acc0_d;
      acc1_q <= acc1_d;
      opr0_q <= opr0_d;
      opr1_q <= opr1_d;
      ctrl_q <= ctrl_d;
      held_q <= held_d;
      carry_q <= carry_d;
      sout_q <= sout_d;
      omask_q <= omask_d;
      poly_q <= poly_d;
      cmask0_q <= cmask0_d;
      cmask1_q <= cmask1_d;
      sticky_q <= sticky_d;
      osel_q <= osel_d;
      msb_q <= msb_d;
      cmpsel_q <= cmpsel_d;
      qdir_q <= qdir_d;
      clken_q <= clken_d;
      chain_q <= chain_d;
      cfg_q <= cfg_d;
      bus_rdata_q <= rdata_d;
      // Routing outputs freeze while the datapath is stopped
      if (run) begin
        route_out_q <= rout_d;
      end
      // Control output follows the register only while its unit runs
      if (sc_run) begin
        ctrl_out_q <= ctrl_d;
      end
      chain_carry_out_q <= cco_d;
      chain_shift_out_q <= cso_d;
      chain_cond_out_q <= ccond_d;
    end
  end
endmodule

// >>> tb/dp_monitor.sv
// Checker for the datapath bus, control and status ports.
// Sees only the top module's ports; attached to every instance by the bind at the foot.
`timescale 1ns/1ps
module dp_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Bus and routing
  input wire dp_pkg::bus_req_s bus_req,
  input wire logic [7:0] bus_rdata_q,
  input wire logic [5:0] route_out_q,
  input wire logic [7:0] status_route,
  input wire logic [7:0] ctrl_out_q
);
  logic [7:0] stick_q;
  logic clk1_q;
  logic rd, wc, rs;
  logic [7:0] ev;
  assign rd = bus_req.sel && !bus_req.wr;
  assign wc = bus_req.sel && bus_req.wr && bus_req.addr == dp_pkg::OFS_CTRL;
  assign rs = rd && bus_req.addr == dp_pkg::OFS_STAT;
  // Masked by reset so a capture is never expected across a reset
  assign ev = status_route & stick_q & {8{!sys_rst}};
  // Shadow of the settings that decide what status and control show
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stick_q <= 8'h00;
      clk1_q <= 1'b1;
    end else if (bus_req.sel && bus_req.wr && bus_req.addr == dp_pkg::OFS_STICKY) begin
      stick_q <= bus_req.wdata;
    end else if (bus_req.sel && bus_req.wr && bus_req.addr == dp_pkg::OFS_CLKEN) begin
      clk1_q <= bus_req.wdata[1];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!rd |=> bus_rdata_q == 8'h00)
    else $error("read data not zero without a read");
  a_unmapped_zero: assert property (rd && bus_req.addr inside {[6'h16:6'h1F], [6'h30:6'h3F]} |=> bus_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_write: assert property (wc && clk1_q |=> ctrl_out_q == $past(bus_req.wdata))
    else $error("control output missed a write");
  a_ctrl_hold: assert property (!wc |=> $stable(ctrl_out_q))
    else $error("control output changed without a write");
  a_ctrl_read: assert property (rd && bus_req.addr == dp_pkg::OFS_CTRL && clk1_q |=> bus_rdata_q == $past(ctrl_out_q))
    else $error("control readback differs");
  a_stat_live: assert property (rs |=> ((bus_rdata_q ^ $past(status_route)) & ~$past(stick_q)) == 8'h00)
    else $error("live status bits differ");
  a_sticky_hold: assert property (rs && clk1_q && !$past(rs) |=> (bus_rdata_q & $past(ev, 2)) == $past(ev, 2))
    else $error("held status bit lost");
  a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> bus_rdata_q == 8'h00 && ctrl_out_q == 8'h00 && route_out_q == 6'h00)
    else $error("outputs not cleared by reset");
  c_ctrl_write: cover property (wc);
  c_stat_read: cover property (rs);
  c_queue_read: cover property (rd && bus_req.addr == dp_pkg::OFS_QUE1);
endmodule
bind programmable_block_datapath dp_monitor mon (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req),
  .bus_rdata_q(bus_rdata_q), .route_out_q(route_out_q), .status_route(status_route), .ctrl_out_q(ctrl_out_q));

// >>> tb/dp_host_model.sv
// Bus master standing in for firmware or DMA: one access per call.
// Drives at the falling edge; read data is taken at the falling edge after the read edge.
`timescale 1ns/1ps
module dp_host_model (
  // Clock
  input wire logic clk_sys,
  // Bus port and read data
  output dp_pkg::bus_req_s bus_req,
  input wire logic [7:0] bus_rdata_q
);
  initial bus_req = '0;
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_sys);
    bus_req = '{sel: 1'b1, wr: w, addr: a, wdata: d};
    @(negedge clk_sys);
    q = bus_rdata_q;
    // Idle fields inverted so stale values cannot pass for a request
    bus_req = '{sel: 1'b0, wr: ~w, addr: ~a, wdata: ~d};
  endtask
endmodule

// >>> tb/programmable_block_datapath_tb.sv
// Self-checking bench: reset, ALU and shifts, queues, control, status and routing outputs.
// Uses dp_host_model as bus master; the checker attaches through its bind.
`timescale 1ns/1ps
module programmable_block_datapath_tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  dp_pkg::bus_req_s bus_req;
  logic [7:0] rdata, q, a, b, e;
  logic [7:0] sr = 8'h00;
  logic [5:0] route_in = 6'h01;
  logic [5:0] route_out_q;
  logic [7:0] ctrl_out_q;
  logic ci = 1'b0;
  logic cc_out, cs_out, cd_out;
  logic [2:0] chain_seen;
  int failures = 0;
  int checks_done = 0;
  logic [7:0] model_q[$];
  logic [5:0] zofs[6] = '{dp_pkg::OFS_ACC0, dp_pkg::OFS_ACC1, dp_pkg::OFS_OPR0, dp_pkg::OFS_OPR1,
    dp_pkg::OFS_CTRL, 6'h16};
  dp_pkg::cfg_word_s c;
  initial forever #20 clk_sys = ~clk_sys;
  dp_host_model host (.clk_sys(clk_sys), .bus_req(bus_req), .bus_rdata_q(rdata));
  programmable_block_datapath uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata_q(rdata),
    .route_in(route_in), .route_out_q(route_out_q), .status_route(sr), .ctrl_out_q(ctrl_out_q),
    .chain_carry_in(ci), .chain_shift_in(ci), .chain_cond_in(ci), .chain_carry_out_q(cc_out),
    .chain_shift_out_q(cs_out), .chain_cond_out_q(cd_out));
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    host.acc(1'b1, ad, d, q);
  endtask
  task automatic rd(input logic [5:0] ad, output logic [7:0] d);
    host.acc(1'b0, ad, 8'h00, d);
  endtask
  // Word 1 stays all zero as the idle operation; word 0 runs for exactly one edge
  task automatic step(input dp_pkg::cfg_word_s w);
    wr(dp_pkg::OFS_CFG, w[7:0]);
    wr(dp_pkg::OFS_CFG + 6'h01, w[15:8]);
    @(negedge clk_sys);
    route_in[2:0] = 3'h0;
    @(negedge clk_sys);
    // Chain outputs stand for one cycle only, so they are caught before word 1 runs again
    chain_seen = {cc_out, cs_out, cd_out};
    route_in[2:0] = 3'h1;
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [7:0] model(input int f, input logic [7:0] x, input logic [7:0] y);
    case (f)
      1: return x + 8'h01;
      2: return x - 8'h01;
      3: return x + y;
      4: return x - y;
      5: return x & y;
      6: return x | y;
      7: return x ^ y;
      8: return {x[6:0], 1'b0};
      9: return {1'b0, x[7:1]};
      10: return {x[3:0], x[7:4]};
      default: return x;
    endcase
  endfunction
  initial begin
    #400000;
    failures++;
    test_done();
  end
  initial begin
    void'($urandom(6));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    foreach (zofs[i]) begin
      rd(zofs[i], e);
      chk("reset reg", e, 8'h00);
    end
    rd(dp_pkg::OFS_QSTAT, e);
    chk("reset qstat", e, 8'h0A);
    wr(dp_pkg::OFS_OSEL0, 8'h4C);
    repeat (3) @(negedge clk_sys);
    chk("route out", {2'b00, route_out_q}, 8'h3F);
    $display("reset test done");
    for (int f = 0; f < 11; f++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      ci = a[0];
      wr(dp_pkg::OFS_ACC0, a);
      wr(dp_pkg::OFS_OPR0, b);
      c = '0;
      c.fn = dp_pkg::alu_fn_e'(f < 8 ? f : 0);
      c.shift = dp_pkg::shift_e'(f < 8 ? 0 : f - 7);
      c.src_b = 2'h2;
      c.wr_acc0 = 1'b1;
      step(c);
      rd(dp_pkg::OFS_ACC0, e);
      chk("alu result", e, model(f, a, b));
      e = {5'h00, f == 1 ? a == 8'hFF : f == 2 ? a == 8'h00 : f == 3 ? 9'(a) + 9'(b) > 9'h0FF : f == 4 && a < b,
        f == 8 ? a[7] : f == 9 && a[0], a == b};
      chk("chain out", {5'h00, chain_seen}, e);
    end
    a = 8'($urandom);
    b = 8'($urandom);
    wr(dp_pkg::OFS_POLY, b);
    wr(dp_pkg::OFS_ACC0, a);
    c = '0;
    c.crc_en = 1'b1;
    c.wr_acc0 = 1'b1;
    step(c);
    rd(dp_pkg::OFS_ACC0, e);
    chk("crc step", e, {a[6:0], 1'b0} ^ (a[7] ? b : 8'h00));
    rd(6'h30, e);
    chk("unmapped read", e, 8'h00);
    $display("alu test done");
    for (int i = 0; i < 5; i++) begin
      a = 8'($urandom);
      if (i < 4) model_q.push_back(a);
      // The fifth write meets a full queue on purpose
      wr(dp_pkg::OFS_QUE0, a);
    end
    rd(dp_pkg::OFS_QSTAT, e);
    chk("full qstat", e, 8'h09);
    c = '0;
    c.q_load = 1'b1;
    repeat (4) begin
      step(c);
      rd(dp_pkg::OFS_ACC0, e);
      chk("queue load", e, model_q.pop_front());
    end
    rd(dp_pkg::OFS_QSTAT, e);
    chk("empty qstat", e, 8'h0A);
    wr(dp_pkg::OFS_QDIR, 8'h02);
    c = '0;
    c.q1_push = 1'b1;
    repeat (2) begin
      a = 8'($urandom);
      model_q.push_back(a);
      wr(dp_pkg::OFS_ACC0, a);
      step(c);
    end
    repeat (2) begin
      rd(dp_pkg::OFS_QUE1, e);
      chk("output queue", e, model_q.pop_front());
    end
    $display("queue test done");
    a = 8'($urandom);
    wr(dp_pkg::OFS_CTRL, a);
    chk("ctrl out", ctrl_out_q, a);
    wr(dp_pkg::OFS_STICKY, 8'h01);
    @(negedge clk_sys);
    sr = 8'h01;
    @(negedge clk_sys);
    sr = 8'hA4;
    rd(dp_pkg::OFS_STAT, e);
    chk("status held", e, 8'hA5);
    rd(dp_pkg::OFS_STAT, e);
    chk("status cleared", e, 8'hA4);
    $display("status test done");
    test_done();
  end
endmodule
